// ### rtl/rwcm_reset_watchdog.sv
// reset generation: power-on, reset pin, watchdog and clock monitor
//
// Overview of operation
// - reset enters from power-on, reset pin low, watchdog expiry or clock failure
// - power-on holds reset for a delay, then until the pin is high
// - open-drain pull-down drives the reset pin low during power-up
// - pin low for eight bus cycles resets; the far side holds it that long
// - enabled watchdog expiry resets the system and drives the pin low
// - failure flag set by watchdog or monitor reset, cleared by control read
// - watchdog enable readable always, writable only once after reset
// - timeout select cleared by reset, writable only once after reset
// - watchdog period is bus clock over 2^15 times 1, 4, 16 or 64
// - writing 0x55 then 0xaa to the service register restarts the count
// - enabled clock monitor resets on slow or missing clock, never if off
// - no monitor reset above about 200 kHz; reset and pin drive below 10 kHz
// - enabled monitor treats a stop-mode halted clock as a failure
// - clock monitor enable is freely readable and writable
// - upper three control bits always read zero
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module rwcm_reset_watchdog
#(
  parameter int PorDelayCycles = rwcm_pkg::POR_DELAY_CYCLES,
  parameter int ExtMinCycles = rwcm_pkg::EXT_RESET_MIN_CYCLES,
  parameter int PinDriveCycles = rwcm_pkg::PIN_DRIVE_CYCLES
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire rwcm_pkg::rwcm_wb_req_s wbReq,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  input wire logic busClockSlow,
  input wire logic stopMode,
  output logic sysReset_n,
  output logic irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  localparam int WdWidth = rwcm_pkg::WATCHDOG_BASE_SHIFT + 6;

  // last count of a period: 2^15 times 1, 4, 16 or 64, minus one
  function automatic logic [WdWidth-1:0] wdLastCount(input logic [1:0] sel);
    logic [WdWidth-1:0] one;
    one = {{(WdWidth-1){1'b0}}, 1'b1};
    wdLastCount = (one << (rwcm_pkg::WATCHDOG_BASE_SHIFT + 2 * int'(sel)))
      - one;
  endfunction : wdLastCount

  // ****************************************************************
  // declarations
  // ****************************************************************
  rwcm_pkg::rwcm_state_e state_reg, state_next;
  logic [15:0] stateCount_reg;
  logic [3:0] extLowCount_reg;
  logic [WdWidth-1:0] wdCount_reg;
  logic serviceArmed_reg;
  logic failureFlag_reg;
  logic monitorEnable_reg;
  logic watchdogEnable_reg;
  logic [1:0] timeoutSelect_reg;
  logic controlWritten_reg;
  logic [2:0] irqStatus_reg, irqStatus_next;
  logic [2:0] irqMask_reg;
  logic busReq, busWrite, busRead, lane0;
  logic ctrlWrite, ctrlRead, serviceWrite;
  logic inRun, wdExpire, monitorFail, extLow8, internalReset;
  logic [7:0] controlView;
  logic [31:0] readData;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // a request is acted on in the cycle before its ack
  assign busReq = wbReq.cyc & wbReq.stb & ~wbAck;
  assign busWrite = busReq & wbReq.we;
  assign busRead = busReq & ~wbReq.we;
  assign lane0 = wbReq.sel[0];
  assign ctrlWrite = busWrite & lane0
    & (wbReq.adr == rwcm_pkg::WATCHDOG_CONTROL_OFS);
  assign ctrlRead = busRead & (wbReq.adr == rwcm_pkg::WATCHDOG_CONTROL_OFS);
  assign serviceWrite = busWrite & lane0
    & (wbReq.adr == rwcm_pkg::WATCHDOG_SERVICE_REGISTER_OFS);

  // ****************************************************************
  // reset sources
  // ****************************************************************
  assign inRun = (state_reg == rwcm_pkg::ST_RUN);
  // expiry only counts while enabled
  assign wdExpire = inRun & watchdogEnable_reg
    & (wdCount_reg == wdLastCount(timeoutSelect_reg));
  // detector flags below the fail threshold; stop mode halts the clock
  assign monitorFail = inRun & monitorEnable_reg
    & (busClockSlow | stopMode);
  assign extLow8 = inRun & ~resetPinIn
    & (extLowCount_reg == 4'(ExtMinCycles - 1));
  // controls go back to reset values whenever the system is held
  assign internalReset = ~inRun;

  // ****************************************************************
  // reset sequencer
  // ****************************************************************
  // watchdog and monitor beat the pin when they coincide
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      rwcm_pkg::ST_POR:
      begin
        if (stateCount_reg == 16'(PorDelayCycles - 1))
          state_next = resetPinIn ? rwcm_pkg::ST_RUN
                                  : rwcm_pkg::ST_WAIT_PIN;
      end
      rwcm_pkg::ST_RUN:
      begin
        if (wdExpire | monitorFail)
          state_next = rwcm_pkg::ST_DRIVE;
        else if (extLow8)
          state_next = rwcm_pkg::ST_WAIT_PIN;
      end
      rwcm_pkg::ST_DRIVE:
      begin
        if (stateCount_reg == 16'(PinDriveCycles - 1))
          state_next = rwcm_pkg::ST_WAIT_PIN;
      end
      rwcm_pkg::ST_WAIT_PIN:
      begin
        if (resetPinIn)
          state_next = rwcm_pkg::ST_RUN;
      end
    endcase
  end

  // state and its dwell counter
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= rwcm_pkg::ST_POR;
      stateCount_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next != state_reg)
        stateCount_reg <= 16'h0000;
      else
        stateCount_reg <= stateCount_reg + 16'h0001;
    end
  end

  // consecutive low samples of the pin while running
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      extLowCount_reg <= 4'h0;
    else if (!inRun || resetPinIn)
      extLowCount_reg <= 4'h0;
    else if (extLowCount_reg != 4'(ExtMinCycles - 1))
      extLowCount_reg <= extLowCount_reg + 4'h1;
  end

  // pin pull-down during power-up and after an internal failure
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      resetPinOe <= 1'b1;
      resetPinOut <= 1'b0;
      sysReset_n <= 1'b0;
    end
    else
    begin
      resetPinOe <= (state_next == rwcm_pkg::ST_POR)
        | (state_next == rwcm_pkg::ST_DRIVE);
      resetPinOut <= 1'b0;
      sysReset_n <= (state_next == rwcm_pkg::ST_RUN);
    end
  end

  // ****************************************************************
  // watchdog counter and service sequence
  // ****************************************************************
  // counter runs freely; enable only gates the expiry
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wdCount_reg <= '0;
    else if (internalReset)
      wdCount_reg <= '0;
    else if (serviceWrite && serviceArmed_reg
             && wbReq.dat[7:0] == rwcm_pkg::SERVICE_FIRE_KEY)
      wdCount_reg <= '0;
    else if (wdCount_reg == wdLastCount(timeoutSelect_reg))
      wdCount_reg <= '0;
    else
      wdCount_reg <= wdCount_reg + {{(WdWidth-1){1'b0}}, 1'b1};
  end

  // arm on the first key, any other service value disarms
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      serviceArmed_reg <= 1'b0;
    else if (internalReset)
      serviceArmed_reg <= 1'b0;
    else if (serviceWrite)
      serviceArmed_reg <=
        (wbReq.dat[7:0] == rwcm_pkg::SERVICE_ARM_KEY);
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  // enables and timeout select; both write-once fields take one write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      monitorEnable_reg <= 1'b0;
      watchdogEnable_reg <= 1'b0;
      timeoutSelect_reg <= 2'h0;
      controlWritten_reg <= 1'b0;
    end
    else if (internalReset)
    begin
      monitorEnable_reg <= 1'b0;
      watchdogEnable_reg <= 1'b0;
      timeoutSelect_reg <= 2'h0;
      controlWritten_reg <= 1'b0;
    end
    else if (ctrlWrite)
    begin
      monitorEnable_reg <=
        wbReq.dat[rwcm_pkg::CLOCK_MONITOR_ENABLE_BIT];
      controlWritten_reg <= 1'b1;
      if (!controlWritten_reg)
      begin
        watchdogEnable_reg <= wbReq.dat[rwcm_pkg::WATCHDOG_ENABLE_BIT];
        timeoutSelect_reg <=
          {wbReq.dat[rwcm_pkg::TIMEOUT_SELECT_HIGH_BIT],
           wbReq.dat[rwcm_pkg::TIMEOUT_SELECT_LOW_BIT]};
      end
    end
  end

  // failure flag survives every reset but power-on; set beats read clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      failureFlag_reg <= 1'b0;
    else if (wdExpire || monitorFail)
      failureFlag_reg <= 1'b1;
    else if (ctrlRead)
      failureFlag_reg <= 1'b0;
  end

  // upper bits tied low
  always_comb
  begin
    controlView = rwcm_pkg::CONTROL_RESET;
    controlView[rwcm_pkg::FAILURE_FLAG_BIT] = failureFlag_reg;
    controlView[rwcm_pkg::CLOCK_MONITOR_ENABLE_BIT] = monitorEnable_reg;
    controlView[rwcm_pkg::WATCHDOG_ENABLE_BIT] = watchdogEnable_reg;
    controlView[rwcm_pkg::TIMEOUT_SELECT_HIGH_BIT] = timeoutSelect_reg[1];
    controlView[rwcm_pkg::TIMEOUT_SELECT_LOW_BIT] = timeoutSelect_reg[0];
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  // held across internal resets so software can see what happened
  always_comb
  begin
    irqStatus_next = irqStatus_reg;
    if (busWrite && lane0 && wbReq.adr == rwcm_pkg::IRQ_STATUS_OFS)
      irqStatus_next = irqStatus_reg & ~wbReq.dat[2:0];
    if (wdExpire)
      irqStatus_next[rwcm_pkg::IRQ_WATCHDOG_BIT] = 1'b1;
    if (monitorFail)
      irqStatus_next[rwcm_pkg::IRQ_CLOCK_MONITOR_BIT] = 1'b1;
    if (extLow8)
      irqStatus_next[rwcm_pkg::IRQ_EXT_RESET_BIT] = 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqStatus_reg <= rwcm_pkg::IRQ_RESET;
      irqMask_reg <= rwcm_pkg::IRQ_RESET;
      irq <= 1'b0;
    end
    else
    begin
      irqStatus_reg <= irqStatus_next;
      if (busWrite && lane0 && wbReq.adr == rwcm_pkg::IRQ_MASK_OFS)
        irqMask_reg <= wbReq.dat[2:0];
      irq <= |(irqStatus_next & irqMask_reg);
    end
  end

  // ****************************************************************
  // bus answer
  // ****************************************************************
  // unmapped addresses answer zero and drop writes
  always_comb
  begin
    readData = 32'h0000_0000;
    unique case (wbReq.adr)
      rwcm_pkg::WATCHDOG_CONTROL_OFS: readData = {24'h00_0000, controlView};
      rwcm_pkg::IRQ_STATUS_OFS: readData = {29'h0000_0000, irqStatus_reg};
      rwcm_pkg::IRQ_MASK_OFS: readData = {29'h0000_0000, irqMask_reg};
      default: readData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end
    else
    begin
      wbAck <= busReq;
      wbDatOut <= busRead ? readData : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  por_pin_drive_a: assert property (@(posedge clk)
    disable iff (!arst_n) state_reg == rwcm_pkg::ST_POR |-> resetPinOe)
    else $error("pin not driven during power-up");

  ext_low_reset_a: assert property (@(posedge clk)
    disable iff (!arst_n) (inRun && !resetPinIn)[*8]
      |=> !inRun && !sysReset_n)
    else $error("eight low pin cycles did not reset");

  wd_expire_drive_a: assert property (@(posedge clk)
    disable iff (!arst_n) wdExpire |=> resetPinOe && !sysReset_n
      && state_reg == rwcm_pkg::ST_DRIVE)
    else $error("watchdog expiry did not drive the pin");

  fail_flag_set_a: assert property (@(posedge clk)
    disable iff (!arst_n) (wdExpire || monitorFail) |=> failureFlag_reg)
    else $error("failure flag not set");

  read_clears_a: assert property (@(posedge clk)
    disable iff (!arst_n) ctrlRead && !wdExpire && !monitorFail
      |=> !failureFlag_reg && wbDatOut[4] == $past(failureFlag_reg))
    else $error("control read did not clear the flag");

  enable_once_a: assert property (@(posedge clk)
    disable iff (!arst_n) inRun && $past(inRun) && $past(controlWritten_reg)
      |-> $stable(watchdogEnable_reg) && $stable(timeoutSelect_reg))
    else $error("write-once field changed");

  service_restart_a: assert property (@(posedge clk)
    disable iff (!arst_n) inRun && serviceWrite && serviceArmed_reg
      && wbReq.dat[7:0] == rwcm_pkg::SERVICE_FIRE_KEY
      |=> wdCount_reg == '0)
    else $error("service pair did not restart the count");

  monitor_off_a: assert property (@(posedge clk)
    disable iff (!arst_n) inRun && !monitorEnable_reg && !wdExpire
      |=> state_reg != rwcm_pkg::ST_DRIVE)
    else $error("disabled monitor caused a failure");

  stop_fail_a: assert property (@(posedge clk)
    disable iff (!arst_n) inRun && monitorEnable_reg && stopMode
      |=> resetPinOe ##1 !sysReset_n)
    else $error("stop with monitor enabled did not reset");

  upper_zero_a: assert property (@(posedge clk)
    disable iff (!arst_n) wbAck && $past(ctrlRead) |-> wbDatOut[7:5] == 3'h0)
    else $error("unused control bits read nonzero");

endmodule : rwcm_reset_watchdog

`default_nettype wire

// ### rtl/rwcm_pkg.sv
// constants, field layout and bus carrier of the reset, watchdog and clock monitor block
package rwcm_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] WATCHDOG_CONTROL_OFS = 8'h00;
  localparam logic [7:0] WATCHDOG_SERVICE_REGISTER_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

  // ****************************************************************
  // control register fields and reset values
  // ****************************************************************
  localparam int FAILURE_FLAG_BIT = 4;
  localparam int CLOCK_MONITOR_ENABLE_BIT = 3;
  localparam int WATCHDOG_ENABLE_BIT = 2;
  localparam int TIMEOUT_SELECT_HIGH_BIT = 1;
  localparam int TIMEOUT_SELECT_LOW_BIT = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // interrupt status / mask bit positions
  localparam int IRQ_WATCHDOG_BIT = 0;
  localparam int IRQ_CLOCK_MONITOR_BIT = 1;
  localparam int IRQ_EXT_RESET_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // service key values
  localparam logic [7:0] SERVICE_ARM_KEY = 8'h55;
  localparam logic [7:0] SERVICE_FIRE_KEY = 8'haa;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int WATCHDOG_BASE_SHIFT = 15;
  localparam int EXT_RESET_MIN_CYCLES = 8;
  localparam int PIN_DRIVE_CYCLES = 16;
  localparam int POR_DELAY_CYCLES = 4064;
  // slow-clock detector thresholds, realised by the analog detector
  localparam int MONITOR_SAFE_KHZ = 200;
  localparam int MONITOR_FAIL_KHZ = 10;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rwcm_wb_req_s;

  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_RUN = 2'b01,
    ST_DRIVE = 2'b10,
    ST_WAIT_PIN = 2'b11
  } rwcm_state_e;

endpackage : rwcm_pkg

// ### verif/rwcm_pin_partner.sv
// model of the external reset circuitry on the shared open-drain reset pin
`timescale 1ns/10ps
`default_nettype none

module rwcm_pin_partner
(
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic holdLow,
  output logic pinLevel
);
  // ****************************************************************
  // wired reset pin
  // ****************************************************************
  logic blockPull;
  logic extPull;

  // the block only ever pulls down; a high out value is no drive at all
  assign blockPull = resetPinOe && (resetPinOut === 1'b0);
  // external supervisor holds the pin low as long as the bench asks
  assign extPull = (holdLow === 1'b1);
  // pull-up wins only when nobody drives, so a released pin reads high
  assign pinLevel = (blockPull || extPull) ? 1'b0 : 1'b1;
endmodule : rwcm_pin_partner

`default_nettype wire

// ### verif/rwcm_reset_watchdog_bench.sv
// self-checking bench for the reset, watchdog and clock monitor block
`timescale 1ns/10ps
`default_nettype none

module rwcm_reset_watchdog_bench;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  localparam int PorCycles = 20;
  localparam logic [7:0] Ctl = rwcm_pkg::WATCHDOG_CONTROL_OFS;
  localparam logic [7:0] Svc = rwcm_pkg::WATCHDOG_SERVICE_REGISTER_OFS;
  localparam logic [7:0] Sts = rwcm_pkg::IRQ_STATUS_OFS;
  localparam logic [7:0] Msk = rwcm_pkg::IRQ_MASK_OFS;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  rwcm_pkg::rwcm_wb_req_s wbReq = '0;
  logic [31:0] wbDatOut;
  logic wbAck;
  logic resetPinOut;
  logic resetPinOe;
  logic sysReset_n;
  logic irq;
  logic pinLevel;
  logic holdLow = 1'b1;
  logic busClockSlow = 1'b0;
  logic stopMode = 1'b0;
  int n_mismatch = 0;
  int compares = 0;
  int n;

  // 20 MHz bus clock
  always #25 clk = ~clk;

  rwcm_reset_watchdog #(.PorDelayCycles(PorCycles)) rwcm_reset_watchdog_inst
  (
    .clk(clk), .arst_n(arst_n), .wbReq(wbReq), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .resetPinIn(pinLevel), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .busClockSlow(busClockSlow),
    .stopMode(stopMode), .sysReset_n(sysReset_n), .irq(irq)
  );

  rwcm_pin_partner rwcm_pin_partner_inst
  (
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .holdLow(holdLow), .pinLevel(pinLevel)
  );

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one classic cycle; values read right after an edge are pre-edge ones
  task automatic wbAccess(input logic w, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
    int k;
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf,
               dat: {24'h0, d}};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wbAck !== 1'b1 && k < 20);
    q = wbDatOut[7:0];
    wbReq <= '0;
    if (wbAck !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] bus ack expected 1 seen %b", wbAck);
      test_done();
    end
  endtask : wbAccess

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wbAccess(1'b1, a, d, q);
  endtask : wr

  task automatic rdChk(input string what, input logic [7:0] a,
                       input logic [7:0] exp);
    logic [7:0] q;
    wbAccess(1'b0, a, 8'h00, q);
    chk(what, {24'h0, exp}, {24'h0, q});
  endtask : rdChk

  // bounded wait for the system reset level; cyc counts the edges
  task automatic waitRst(input logic lvl, input int lim, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk);
      cyc++;
    end
    while (sysReset_n !== lvl && cyc < lim);
    if (sysReset_n !== lvl)
    begin
      n_mismatch++;
      $display("[FAIL] system reset expected %b seen %b", lvl, sysReset_n);
      test_done();
    end
  endtask : waitRst

  // external supervisor pulls the pin low for len edges
  task automatic pinPulse(input int len);
    @(posedge clk);
    holdLow <= 1'b1;
    repeat (len) @(posedge clk);
    holdLow <= 1'b0;
  endtask : pinPulse

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    // power-on: pin pulled by the block, then held by the supervisor
    repeat (10) @(posedge clk);
    chk("pin drive at power-up", 32'h1, {31'h0, resetPinOe});
    chk("reset during power-on", 32'h0, {31'h0, sysReset_n});
    repeat (PorCycles + 10) @(posedge clk);
    chk("reset while pin held", 32'h0, {31'h0, sysReset_n});
    holdLow <= 1'b0;
    waitRst(1'b1, 10, n);
    // control layout, reset values, write-once fields
    rdChk("control after reset", Ctl, 8'h00);
    rdChk("unmapped read", 8'h10, 8'h00);
    wr(Ctl, 8'he4);
    rdChk("control first write", Ctl, 8'h04);
    wr(Ctl, 8'h07);
    rdChk("control second write", Ctl, 8'h04);
    wr(Ctl, 8'h0c);
    rdChk("monitor enable set", Ctl, 8'h0c);
    wr(Ctl, 8'h04);
    rdChk("monitor enable cleared", Ctl, 8'h04);
    // a seven-edge pin pulse is too short to count
    pinPulse(7);
    repeat (4) @(posedge clk);
    chk("short pin pulse", 32'h1, {31'h0, sysReset_n});
    // keep the watchdog serviced, other traffic between the two keys
    repeat (2)
    begin
      wr(Svc, 8'h55);
      rdChk("control between keys", Ctl, 8'h04);
      wr(Svc, 8'haa);
      repeat (25000) @(posedge clk);
      chk("serviced watchdog", 32'h1, {31'h0, sysReset_n});
    end
    wr(Svc, 8'h55);
    wr(Svc, 8'haa);
    // unserviced: expiry after 2^15 edges with select 00
    waitRst(1'b0, 40000, n);
    chk("watchdog period", 32'h1, {31'h0, n >= 32760 && n <= 32780});
    chk("pin driven on expiry", 32'h1, {31'h0, resetPinOe});
    chk("pin level on expiry", 32'h0, {31'h0, pinLevel});
    chk("pin out value", 32'h0, {31'h0, resetPinOut});
    waitRst(1'b1, 100, n);
    rdChk("failure flag set", Ctl, 8'h10);
    rdChk("failure flag read-clear", Ctl, 8'h00);
    // interrupt: status, mask, level output, write-one clear
    rdChk("status after expiry", Sts, 8'h01);
    wr(Msk, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(Sts, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // eight-edge pin pulse resets; failure flag untouched
    pinPulse(8);
    waitRst(1'b0, 4, n);
    waitRst(1'b1, 20, n);
    rdChk("flag after pin reset", Ctl, 8'h00);
    rdChk("status after pin reset", Sts, 8'h04);
    chk("irq masked", 32'h0, {31'h0, irq});
    // monitor off: halted clock never resets; monitor on: slow clock resets
    wr(Ctl, 8'h00);
    stopMode <= 1'b1;
    repeat (20) @(posedge clk);
    chk("stop with monitor off", 32'h1, {31'h0, sysReset_n});
    stopMode <= 1'b0;
    wr(Ctl, 8'h08);
    busClockSlow <= 1'b1;
    waitRst(1'b0, 20, n);
    chk("pin driven on slow clock", 32'h1, {31'h0, resetPinOe});
    busClockSlow <= 1'b0;
    waitRst(1'b1, 100, n);
    rdChk("flag after monitor reset", Ctl, 8'h10);
    // monitor on at stop: halted clock is a failure
    wr(Ctl, 8'h08);
    stopMode <= 1'b1;
    waitRst(1'b0, 20, n);
    stopMode <= 1'b0;
    waitRst(1'b1, 100, n);
    wr(Msk, 8'h06);
    repeat (2) @(posedge clk);
    chk("irq from pin and monitor", 32'h1, {31'h0, irq});
    test_done();
  end
endmodule : rwcm_reset_watchdog_bench

`default_nettype wire
